// >>> design/gpp_pkg.sv
// Package of constants, register map and carrier types for the GPIO port block.
package gpp_pkg;

	// Pins per port and synchroniser depth.
	localparam int unsigned PINS        = 32;
	localparam int unsigned SYNC_STAGES = 3;

	// Per-port defaults: interrupt vector numbers and implemented pin masks.
	localparam logic [7:0]  PORT0_VEC  = 8'h28;
	localparam logic [7:0]  PORT1_VEC  = 8'h29;
	localparam logic [31:0] PORT0_MASK = 32'hffffffff;
	localparam logic [31:0] PORT1_MASK = 32'h0000ffff;

	// Register byte offsets.
	localparam logic [7:0] OFF_EN           = 8'h00;
	localparam logic [7:0] OFF_EN_SET       = 8'h04;
	localparam logic [7:0] OFF_EN_CLR       = 8'h08;
	localparam logic [7:0] OFF_OUT_EN       = 8'h0c;
	localparam logic [7:0] OFF_OUT_EN_SET   = 8'h10;
	localparam logic [7:0] OFF_OUT_EN_CLR   = 8'h14;
	localparam logic [7:0] OFF_OUT          = 8'h18;
	localparam logic [7:0] OFF_OUT_SET      = 8'h1c;
	localparam logic [7:0] OFF_OUT_CLR      = 8'h20;
	localparam logic [7:0] OFF_IN           = 8'h24;
	localparam logic [7:0] OFF_INT_MOD      = 8'h28;
	localparam logic [7:0] OFF_INT_POL      = 8'h2c;
	localparam logic [7:0] OFF_IN_EN        = 8'h30;
	localparam logic [7:0] OFF_INT_EN       = 8'h34;
	localparam logic [7:0] OFF_INT_EN_SET   = 8'h38;
	localparam logic [7:0] OFF_INT_EN_CLR   = 8'h3c;
	localparam logic [7:0] OFF_INT_STAT     = 8'h40;
	localparam logic [7:0] OFF_INT_CLR      = 8'h48;
	localparam logic [7:0] OFF_WAKE_EN      = 8'h4c;
	localparam logic [7:0] OFF_WAKE_EN_SET  = 8'h50;
	localparam logic [7:0] OFF_WAKE_EN_CLR  = 8'h54;
	localparam logic [7:0] OFF_DUAL_EDGE    = 8'h5c;
	localparam logic [7:0] OFF_PAD_CFG1     = 8'h60;
	localparam logic [7:0] OFF_PAD_CFG2     = 8'h64;
	localparam logic [7:0] OFF_EN1          = 8'h68;
	localparam logic [7:0] OFF_EN1_SET      = 8'h6c;
	localparam logic [7:0] OFF_EN1_CLR      = 8'h70;
	localparam logic [7:0] OFF_EN2          = 8'h74;
	localparam logic [7:0] OFF_EN2_SET      = 8'h78;
	localparam logic [7:0] OFF_EN2_CLR      = 8'h7c;
	localparam logic [7:0] OFF_DS           = 8'hb0;
	localparam logic [7:0] OFF_DS1          = 8'hb4;
	localparam logic [7:0] OFF_PS           = 8'hb8;
	localparam logic [7:0] OFF_VSSEL        = 8'hc0;

	// Reset values of the stored registers.
	localparam logic [31:0] RST_ONES = 32'hffffffff;
	localparam logic [31:0] RST_ZERO = 32'h00000000;

	// Stored registers.
	typedef enum logic [4:0] {
		R_EN, R_EN1, R_EN2, R_OUT_EN, R_OUT, R_INT_MOD, R_INT_POL, R_IN_EN, R_INT_EN,
		R_WAKE_EN, R_DUAL, R_PAD1, R_PAD2, R_DS, R_DS1, R_PS, R_VSSEL
	} gpp_reg_t;
	localparam int unsigned NREG = 17;

	// Write operation and read source of a decoded address.
	typedef enum logic [2:0] {OP_NONE, OP_WR, OP_SET, OP_CLR, OP_W1C} gpp_op_t;
	typedef enum logic [1:0] {SRC_ZERO, SRC_REG, SRC_IN, SRC_STAT} gpp_src_t;

	typedef struct packed {
		gpp_op_t  op;
		gpp_reg_t idx;
		gpp_src_t src;
	} gpp_dec_t;

	// One alternate-function peripheral's drive for all pins of the port.
	typedef struct packed {
		logic [31:0] dout;
		logic [31:0] oe;
	} gpp_af_t;

	// Pad configuration lines for all pins of the port.
	typedef struct packed {
		logic [31:0] in_buf_en;
		logic [31:0] pull_up;
		logic [31:0] pull_down;
		logic [31:0] pull_strong;
		logic [31:0] drive_low;
		logic [31:0] drive_high;
		logic [31:0] supply_high;
	} gpp_pad_t;

	// Reset value of a stored register.
	function automatic logic [31:0] rst_val(input gpp_reg_t r);
		rst_val = (r == R_EN || r == R_IN_EN) ? RST_ONES : RST_ZERO;
	endfunction

	// Address decode; an unmapped offset reads zero and ignores writes.
	function automatic gpp_dec_t decode(input logic [7:0] a);
		decode = '{OP_NONE, R_EN, SRC_ZERO};
		unique case (a)
			OFF_EN:          decode = '{OP_WR,  R_EN,      SRC_REG};
			OFF_EN_SET:      decode = '{OP_SET, R_EN,      SRC_REG};
			OFF_EN_CLR:      decode = '{OP_CLR, R_EN,      SRC_REG};
			OFF_OUT_EN:      decode = '{OP_WR,  R_OUT_EN,  SRC_REG};
			OFF_OUT_EN_SET:  decode = '{OP_SET, R_OUT_EN,  SRC_REG};
			OFF_OUT_EN_CLR:  decode = '{OP_CLR, R_OUT_EN,  SRC_REG};
			OFF_OUT:         decode = '{OP_WR,  R_OUT,     SRC_REG};
			OFF_OUT_SET:     decode = '{OP_SET, R_OUT,     SRC_REG};
			OFF_OUT_CLR:     decode = '{OP_CLR, R_OUT,     SRC_REG};
			OFF_IN:          decode = '{OP_NONE, R_EN,     SRC_IN};
			OFF_INT_MOD:     decode = '{OP_WR,  R_INT_MOD, SRC_REG};
			OFF_INT_POL:     decode = '{OP_WR,  R_INT_POL, SRC_REG};
			OFF_IN_EN:       decode = '{OP_WR,  R_IN_EN,   SRC_REG};
			OFF_INT_EN:      decode = '{OP_WR,  R_INT_EN,  SRC_REG};
			OFF_INT_EN_SET:  decode = '{OP_SET, R_INT_EN,  SRC_REG};
			OFF_INT_EN_CLR:  decode = '{OP_CLR, R_INT_EN,  SRC_REG};
			OFF_INT_STAT:    decode = '{OP_NONE, R_EN,     SRC_STAT};
			OFF_INT_CLR:     decode = '{OP_W1C, R_EN,      SRC_STAT};
			OFF_WAKE_EN:     decode = '{OP_WR,  R_WAKE_EN, SRC_REG};
			OFF_WAKE_EN_SET: decode = '{OP_SET, R_WAKE_EN, SRC_REG};
			OFF_WAKE_EN_CLR: decode = '{OP_CLR, R_WAKE_EN, SRC_REG};
			OFF_DUAL_EDGE:   decode = '{OP_WR,  R_DUAL,    SRC_REG};
			OFF_PAD_CFG1:    decode = '{OP_WR,  R_PAD1,    SRC_REG};
			OFF_PAD_CFG2:    decode = '{OP_WR,  R_PAD2,    SRC_REG};
			OFF_EN1:         decode = '{OP_WR,  R_EN1,     SRC_REG};
			OFF_EN1_SET:     decode = '{OP_SET, R_EN1,     SRC_REG};
			OFF_EN1_CLR:     decode = '{OP_CLR, R_EN1,     SRC_REG};
			OFF_EN2:         decode = '{OP_WR,  R_EN2,     SRC_REG};
			OFF_EN2_SET:     decode = '{OP_SET, R_EN2,     SRC_REG};
			OFF_EN2_CLR:     decode = '{OP_CLR, R_EN2,     SRC_REG};
			OFF_DS:          decode = '{OP_WR,  R_DS,      SRC_REG};
			OFF_DS1:         decode = '{OP_WR,  R_DS1,     SRC_REG};
			OFF_PS:          decode = '{OP_WR,  R_PS,      SRC_REG};
			OFF_VSSEL:       decode = '{OP_WR,  R_VSSEL,   SRC_REG};
			default:         decode = '{OP_NONE, R_EN,     SRC_ZERO};
		endcase
	endfunction

endpackage

// >>> design/gpp_pin_events.sv
// Pin synchroniser, glitch filter and per-pin interrupt event detector.
`timescale 1ns/1ns
module gpp_pin_events (
	// Clock and reset.
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// Raw pad levels from outside the clock domain.
	input  wire logic [31:0] pad_in,
	// Per-pin event configuration.
	input  wire logic [31:0] edge_mode_in,
	input  wire logic [31:0] polarity_in,
	input  wire logic [31:0] both_edges_in,
	input  wire logic [31:0] gate_in,
	input  wire logic [31:0] rearm_in,
	// Filtered level and event per pin; one cycle for an edge, held for as long as a level matches.
	output logic      [31:0] level_out,
	output logic      [31:0] event_out
);

	logic [31:0] s1_r;
	logic [31:0] s2_r;
	logic [31:0] s3_r;
	logic [31:0] lvl_r;
	logic [31:0] prev_r;
	logic [31:0] armed_r;
	wire  [31:0] agree_w;
	wire  [31:0] lvl_nxt;
	wire  [31:0] rise_w;
	wire  [31:0] fall_w;
	wire  [31:0] edge_w;
	wire  [31:0] level_hit_w;
	wire  [31:0] armed_eff_w;
	wire  [31:0] edge_take_w;
	wire  [31:0] armed_nxt;

	// A change is taken only when the second and third stages agree; s1 feeds s2 alone.
	assign agree_w = ~(s2_r ^ s3_r);
	assign lvl_nxt = (agree_w & s3_r) | (~agree_w & lvl_r);

	// Edge and level matching; both-edges overrides polarity.
	assign rise_w      = lvl_r & ~prev_r;
	assign fall_w      = ~lvl_r & prev_r;
	assign edge_w      = (both_edges_in & (rise_w | fall_w)) |
		(~both_edges_in & ((polarity_in & fall_w) | (~polarity_in & rise_w)));
	assign level_hit_w = polarity_in ^ lvl_r;

	// A clear re-arms the edge detector in the same cycle, so an edge then is still caught.
	assign armed_eff_w = armed_r | rearm_in;
	assign edge_take_w = gate_in & edge_mode_in & edge_w & armed_eff_w;
	assign armed_nxt   = armed_eff_w & ~edge_take_w;

	// Five event kinds: low, high, rising, falling, either edge.
	assign event_out = edge_take_w | (gate_in & ~edge_mode_in & level_hit_w);
	assign level_out = lvl_r;

	// Synchroniser and detector state.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			s1_r    <= '0;
			s2_r    <= '0;
			s3_r    <= '0;
			lvl_r   <= '0;
			prev_r  <= '0;
			armed_r <= '1;
		end else begin
			s1_r    <= pad_in;
			s2_r    <= s1_r;
			s3_r    <= s2_r;
			lvl_r   <= lvl_nxt;
			prev_r  <= lvl_r;
			armed_r <= armed_nxt;
		end
	end

endmodule

// >>> design/gpp_port.sv
// One GPIO port with alternate-function muxing, pad control, interrupts and an AHB-Lite slave.
`timescale 1ns/1ns
// Functional notes
// - Pin level stays readable in alternate function.
// - Port holds 32 pins, one bit each.
// - Each pin has its own interrupt status and enable bit.
// - Port pins share one interrupt output, vectors 40/41.
// - Low, high, rising, falling, either-edge events.
// - Output from data register or alternate function.
// - Set/clear aliases touch only written ones.
// - Only edge-triggered pins may request wake-up.
// - Port 1 implements only pins 15 to 0.
// - Three select bits pick I/O or function 1-4.
// - Pad input mode and pull strength selects.
// - Drive strength bits and supply select.
// - Reset: I/O mode, input on, hi-Z, disabled.
// - Changing I/O-mode target leaves pin undisturbed.
// - Mode switch allowed at any time, no reset.
// - Event sets status; enabled status raises interrupt.
// - Polarity picks high/rising or low/falling.
// - Both-edges bit triggers on either edge.
// - Clear write drops status and re-arms edge.
module gpp_port #(
	parameter logic [31:0] IMPL_MASK  = gpp_pkg::PORT0_MASK,
	parameter logic [7:0]  IRQ_VECTOR = gpp_pkg::PORT0_VEC
) (
	// Clock and reset.
	input  wire logic                       CLK_IN,
	input  wire logic                       RST_IN,
	// AHB-Lite slave.
	input  wire logic                       HSEL_IN,
	input  wire logic [31:0]                HADDR_IN,
	input  wire logic [1:0]                 HTRANS_IN,
	input  wire logic                       HWRITE_IN,
	input  wire logic [2:0]                 HSIZE_IN,
	input  wire logic [31:0]                HWDATA_IN,
	input  wire logic                       HREADY_IN,
	output logic      [31:0]                HRDATA_OUT,
	output logic                            HREADYOUT_OUT,
	output logic                            HRESP_OUT,
	// Pads.
	input  wire logic [31:0]                PAD_LEVEL_IN,
	output logic      [31:0]                PAD_DATA_OUT,
	output logic      [31:0]                PAD_OE_OUT,
	output gpp_pkg::gpp_pad_t               PAD_CFG_OUT,
	// Alternate-function peripherals.
	input  wire gpp_pkg::gpp_af_t [3:0]     AF_IN,
	output logic      [3:0][31:0]           AF_GRANT_OUT,
	output logic      [31:0]                PIN_VALUE_OUT,
	// Interrupt and wake-up.
	output logic                            IRQ_OUT,
	output logic      [7:0]                 IRQ_VEC_OUT,
	output logic                            WAKE_OUT
);

	logic [31:0]         regs_r [gpp_pkg::NREG];
	logic [31:0]         regs_nxt [gpp_pkg::NREG];
	logic [31:0]         flags_r;
	logic                dp_wr_r;
	logic                rd_pend_r;
	gpp_pkg::gpp_dec_t   wdec_r;
	gpp_pkg::gpp_dec_t   rdec_r;
	logic                ready_r;
	logic [31:0]         hrdata_r;
	logic [31:0]         pad_data_nxt;
	logic [31:0]         pad_oe_nxt;
	logic [3:0][31:0]    grant_nxt;
	logic [31:0]         level_w;
	logic [31:0]         event_w;

	// Bus decode and write qualification.
	wire                 accept_w  = HSEL_IN & HTRANS_IN[1] & HREADY_IN;
	wire [31:0]          wmask_w   = HWDATA_IN & IMPL_MASK;
	wire [31:0]          clr_w     = (dp_wr_r && wdec_r.op == gpp_pkg::OP_W1C) ? wmask_w : 32'h00000000;
	wire                 ready_nxt = !(accept_w && !HWRITE_IN);

	// Named views of the stored registers.
	wire [31:0]          io_mode_w = regs_r[gpp_pkg::R_EN];
	wire [31:0]          sel1_w    = regs_r[gpp_pkg::R_EN1];
	wire [31:0]          sel2_w    = regs_r[gpp_pkg::R_EN2];
	wire [31:0]          in_en_w   = regs_r[gpp_pkg::R_IN_EN];
	wire [31:0]          mod_w     = regs_r[gpp_pkg::R_INT_MOD];
	wire [31:0]          pad1_w    = regs_r[gpp_pkg::R_PAD1];
	wire [31:0]          pad2_w    = regs_r[gpp_pkg::R_PAD2];

	// Events count only for implemented pins in I/O mode with the input buffer on.
	wire [31:0]          gate_w    = io_mode_w & in_en_w & IMPL_MASK;
	wire [31:0]          in_read_w = level_w & in_en_w & IMPL_MASK;
	wire [31:0]          flags_nxt = (flags_r & ~clr_w) | event_w;
	wire                 irq_nxt   = |(flags_r & regs_r[gpp_pkg::R_INT_EN]);
	// Level events need the clock running, so only edge-mode pins may wake the part.
	wire                 wake_nxt  = |(flags_r & regs_r[gpp_pkg::R_WAKE_EN] & mod_w);

	// Read data selection for the pending read.
	wire [31:0]          rdata_w   =
		(rdec_r.src == gpp_pkg::SRC_REG)  ? regs_r[rdec_r.idx] :
		(rdec_r.src == gpp_pkg::SRC_IN)   ? in_read_w :
		(rdec_r.src == gpp_pkg::SRC_STAT) ? flags_r : 32'h00000000;

	// Pad configuration; the reserved pull code 11 applies no pull.
	wire gpp_pkg::gpp_pad_t pad_nxt = '{
		in_buf_en:   in_en_w & IMPL_MASK,
		pull_up:     pad1_w & ~pad2_w & IMPL_MASK,
		pull_down:   pad2_w & ~pad1_w & IMPL_MASK,
		pull_strong: regs_r[gpp_pkg::R_PS] & IMPL_MASK,
		drive_low:   regs_r[gpp_pkg::R_DS] & IMPL_MASK,
		drive_high:  regs_r[gpp_pkg::R_DS1] & IMPL_MASK,
		supply_high: regs_r[gpp_pkg::R_VSSEL] & IMPL_MASK
	};

	// Synchroniser and event detection for all pins.
	gpp_pin_events u_events (
		.clk_in        (CLK_IN),
		.rst_in        (RST_IN),
		.pad_in        (PAD_LEVEL_IN),
		.edge_mode_in  (mod_w),
		.polarity_in   (regs_r[gpp_pkg::R_INT_POL]),
		.both_edges_in (regs_r[gpp_pkg::R_DUAL]),
		.gate_in       (gate_w),
		.rearm_in      (clr_w),
		.level_out     (level_w),
		.event_out     (event_w)
	);

	// Register writes in the data phase; set and clear aliases touch only the ones written.
	always_comb begin
		regs_nxt = regs_r;
		if (dp_wr_r) begin
			unique case (wdec_r.op)
				gpp_pkg::OP_WR:  regs_nxt[wdec_r.idx] = wmask_w | (regs_r[wdec_r.idx] & ~IMPL_MASK);
				gpp_pkg::OP_SET: regs_nxt[wdec_r.idx] = regs_r[wdec_r.idx] | wmask_w;
				gpp_pkg::OP_CLR: regs_nxt[wdec_r.idx] = regs_r[wdec_r.idx] & ~wmask_w;
				default:         regs_nxt[wdec_r.idx] = regs_r[wdec_r.idx];
			endcase
		end
	end

	// Pin routing. In I/O mode the function select bits are ignored, so retargeting is glitch free.
	always_comb begin
		pad_data_nxt = '0;
		pad_oe_nxt   = '0;
		grant_nxt    = '0;
		for (int i = 0; i < gpp_pkg::PINS; i++) begin
			if (io_mode_w[i]) begin
				pad_data_nxt[i] = regs_r[gpp_pkg::R_OUT][i];
				pad_oe_nxt[i]   = regs_r[gpp_pkg::R_OUT_EN][i];
			end else begin
				pad_data_nxt[i] = AF_IN[{sel2_w[i], sel1_w[i]}].dout[i];
				pad_oe_nxt[i]   = AF_IN[{sel2_w[i], sel1_w[i]}].oe[i];
				grant_nxt[{sel2_w[i], sel1_w[i]}][i] = 1'b1;
			end
		end
	end

	// Stored registers and interrupt flags; mode may change at any time.
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			for (int r = 0; r < gpp_pkg::NREG; r++) begin
				regs_r[r] <= gpp_pkg::rst_val(gpp_pkg::gpp_reg_t'(r));
			end
			flags_r <= '0;
		end else begin
			regs_r  <= regs_nxt;
			flags_r <= flags_nxt & IMPL_MASK;
		end
	end

	// Bus slave state; reads take one wait state so a write just before is seen.
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			dp_wr_r   <= 1'b0;
			rd_pend_r <= 1'b0;
			wdec_r    <= gpp_pkg::decode(8'h00);
			rdec_r    <= gpp_pkg::decode(8'h00);
			ready_r   <= 1'b1;
			hrdata_r  <= '0;
		end else begin
			dp_wr_r   <= accept_w & HWRITE_IN;
			rd_pend_r <= accept_w & !HWRITE_IN;
			wdec_r    <= accept_w ? gpp_pkg::decode(HADDR_IN[7:0]) : wdec_r;
			rdec_r    <= accept_w ? gpp_pkg::decode(HADDR_IN[7:0]) : rdec_r;
			ready_r   <= ready_nxt;
			hrdata_r  <= rd_pend_r ? rdata_w : hrdata_r;
		end
	end

	// Registered pin and event outputs, masked to the implemented pins.
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			PAD_DATA_OUT  <= '0;
			PAD_OE_OUT    <= '0;
			PAD_CFG_OUT   <= '0;
			AF_GRANT_OUT  <= '0;
			PIN_VALUE_OUT <= '0;
			IRQ_OUT       <= 1'b0;
			IRQ_VEC_OUT   <= IRQ_VECTOR;
			WAKE_OUT      <= 1'b0;
		end else begin
			PAD_DATA_OUT  <= pad_data_nxt & IMPL_MASK;
			PAD_OE_OUT    <= pad_oe_nxt & IMPL_MASK;
			PAD_CFG_OUT   <= pad_nxt;
			AF_GRANT_OUT  <= grant_nxt;
			PIN_VALUE_OUT <= level_w & IMPL_MASK;
			IRQ_OUT       <= irq_nxt;
			IRQ_VEC_OUT   <= IRQ_VECTOR;
			WAKE_OUT      <= wake_nxt;
		end
	end

	assign HRDATA_OUT    = hrdata_r;
	assign HREADYOUT_OUT = ready_r;
	assign HRESP_OUT     = 1'b0;

	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (RST_IN);

	// Checks on the block's own behaviour.
	reset_state_a: assert property ($past(RST_IN) |-> regs_r[gpp_pkg::R_EN] == 32'hffffffff &&
		regs_r[gpp_pkg::R_IN_EN] == 32'hffffffff && regs_r[gpp_pkg::R_OUT_EN] == 32'h00000000 &&
		regs_r[gpp_pkg::R_INT_EN] == 32'h00000000 && regs_r[gpp_pkg::R_PAD1] == 32'h00000000)
		else $error("register state after reset is wrong");
	io_drive_a: assert property (io_mode_w[0] && IMPL_MASK[0] |=>
		PAD_DATA_OUT[0] == $past(regs_r[gpp_pkg::R_OUT][0]) && PAD_OE_OUT[0] == $past(regs_r[gpp_pkg::R_OUT_EN][0]))
		else $error("pin in I/O mode not driven from data register");
	af_route_a: assert property (!io_mode_w[0] && sel1_w[0] && !sel2_w[0] && IMPL_MASK[0] |=>
		PAD_DATA_OUT[0] == $past(AF_IN[1].dout[0]) && AF_GRANT_OUT[1][0])
		else $error("second alternate function not routed");
	flag_set_a: assert property (event_w != 32'h00000000 |=>
		(flags_r & $past(event_w) & IMPL_MASK) == ($past(event_w) & IMPL_MASK))
		else $error("event lost, status bit not set");
	irq_raise_a: assert property ((flags_r & regs_r[gpp_pkg::R_INT_EN]) != 32'h00000000 |=> IRQ_OUT)
		else $error("enabled status did not raise interrupt");
	flag_clear_a: assert property (clr_w[0] && !event_w[0] |=> !flags_r[0])
		else $error("status bit not cleared by clear write");
	set_alias_a: assert property (dp_wr_r && wdec_r.op == gpp_pkg::OP_SET |=>
		(regs_r[$past(wdec_r.idx)] & $past(wmask_w)) == $past(wmask_w) &&
		(regs_r[$past(wdec_r.idx)] & ~$past(wmask_w)) == ($past(regs_r[wdec_r.idx]) & ~$past(wmask_w)))
		else $error("set alias disturbed other bits");
	wake_edge_a: assert property (WAKE_OUT |-> $past(|(flags_r & mod_w)))
		else $error("wake raised by a level-mode pin");
	unimpl_pins_a: assert property ((PAD_OE_OUT & ~IMPL_MASK) == 32'h00000000)
		else $error("unimplemented pin driven");
	read_wait_a: assert property (accept_w && !HWRITE_IN |=> !HREADYOUT_OUT ##1 HREADYOUT_OUT)
		else $error("read wait state not exactly one cycle");

	// Main scenarios.
	irq_seen_c: cover property ($rose(IRQ_OUT));
	wake_seen_c: cover property ($rose(WAKE_OUT));
	af_active_c: cover property (AF_GRANT_OUT[3] != 32'h00000000);
	read_done_c: cover property (rd_pend_r ##1 HREADYOUT_OUT);

endmodule

// >>> verification/gpp_far_model.sv
// Far-side model of the port's pads: external levels plus whatever the port drives.
`timescale 1ns/1ns
module gpp_far_model (
	// Drive from the port.
	input  wire logic [31:0] data_in,
	input  wire logic [31:0] oe_in,
	// Levels that the outside world puts on undriven pins.
	input  wire logic [31:0] ext_in,
	// Resolved pad levels seen by the port.
	output logic      [31:0] level_out
);
	// A driven pin shows the port's value, so the input path can read back its own output.
	assign level_out = (oe_in & data_in) | (~oe_in & ext_in);
endmodule

// >>> verification/test_gpio_port_with_af_mux.sv
// Self-checking bench for the GPIO port: bus, pad setup, outputs, alternate functions and interrupts.
`timescale 1ns/1ns
module test_gpio_port_with_af_mux;
	// Clock, reset and bus.
	logic                   clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
	logic [1:0]             htrans = 2'h0;
	logic [31:0]            haddr = 32'h0, hwdata = 32'h0, hrdata, q, d, s, c, e_out;
	logic                   hready, hresp, irq, wake;
	// Pins, alternate functions and interrupt vector.
	logic [31:0]            pad_lvl, pad_data, pad_oe, pin_val, ext = 32'h0;
	gpp_pkg::gpp_pad_t      pad_cfg;
	gpp_pkg::gpp_af_t [3:0] af = '0;
	logic [3:0][31:0]       grant;
	logic [7:0]             vec;
	logic [31:0]            v [6];
	logic [4:0]             r;
	int                     failures = 0, checks_done = 0, seed = 85;
	// Event table: level-or-edge, polarity, both edges, start level, final level.
	logic [4:0]             ev [5] = '{5'h01, 5'h0a, 5'h11, 5'h1a, 5'h16};
	logic [7:0]             roff [8] = '{gpp_pkg::OFF_EN, gpp_pkg::OFF_EN1, gpp_pkg::OFF_EN2, gpp_pkg::OFF_IN_EN,
		gpp_pkg::OFF_OUT_EN, gpp_pkg::OFF_INT_EN, gpp_pkg::OFF_PAD_CFG1, gpp_pkg::OFF_PAD_CFG2};
	logic [7:0]             coff [6] = '{gpp_pkg::OFF_PAD_CFG1, gpp_pkg::OFF_PAD_CFG2, gpp_pkg::OFF_PS,
		gpp_pkg::OFF_DS, gpp_pkg::OFF_DS1, gpp_pkg::OFF_VSSEL};

	// Free-running system clock.
	always #10 clk = ~clk;

	// Device under test; the single slave's ready is the bus ready.
	gpp_port u_gpp_port (.CLK_IN(clk), .RST_IN(rst), .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans),
		.HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata), .HREADY_IN(hready), .HRDATA_OUT(hrdata),
		.HREADYOUT_OUT(hready), .HRESP_OUT(hresp), .PAD_LEVEL_IN(pad_lvl), .PAD_DATA_OUT(pad_data),
		.PAD_OE_OUT(pad_oe), .PAD_CFG_OUT(pad_cfg), .AF_IN(af), .AF_GRANT_OUT(grant), .PIN_VALUE_OUT(pin_val),
		.IRQ_OUT(irq), .IRQ_VEC_OUT(vec), .WAKE_OUT(wake));
	gpp_far_model u_gpp_far_model (.data_in(pad_data), .oe_in(pad_oe), .ext_in(ext), .level_out(pad_lvl));

	// Compare one value and report a mismatch at once.
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		checks_done++;
		if (seen !== want) begin
			failures++;
			$display("BAD t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask

	// One single transfer; ready and read data are sampled at the rising edge, before that edge's updates.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] dat, output logic [31:0] rv);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		htrans <= 2'h0;
		hwdata <= dat;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		rv = hrdata;
	endtask

	// Register write and checked register read.
	task automatic wr(input logic [7:0] a, input logic [31:0] dat);
		bus(1'b1, a, dat, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] want);
		bus(1'b0, a, 32'h0, q);
		chk(q, want);
		chk({31'h0, hresp}, 32'h0);
	endtask

	// The single place where the run ends.
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// Watchdog: the whole sequence needs well under a millisecond.
	initial begin
		#1000000;
		failures++;
		wrap_up();
	end

	// Main sequence.
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		// Reset state, vector number and an unmapped offset.
		foreach (roff[i]) rd(roff[i], (i == 0 || i == 3) ? 32'hffffffff : 32'h0);
		chk(pad_oe, 32'h0);
		chk(pad_cfg.pull_up | pad_cfg.pull_down, 32'h0);
		chk({24'h0, vec}, 32'h28);
		rd(8'h44, 32'h0);
		// Pad setup lines follow their select bits.
		foreach (v[i]) v[i] = $random(seed);
		foreach (coff[i]) wr(coff[i], v[i]);
		repeat (3) @(negedge clk);
		chk(pad_cfg.pull_up, v[0] & ~v[1]);
		chk(pad_cfg.pull_down, v[1] & ~v[0]);
		chk(pad_cfg.pull_strong, v[2]);
		chk(pad_cfg.drive_low, v[3]);
		chk(pad_cfg.drive_high, v[4]);
		chk(pad_cfg.supply_high, v[5]);
		// Set and clear aliases touch only the ones written.
		for (int i = 0; i < 4; i++) begin
			d = $random(seed);
			s = $random(seed);
			c = $random(seed);
			wr(gpp_pkg::OFF_OUT, d);
			wr(gpp_pkg::OFF_OUT_SET, s);
			wr(gpp_pkg::OFF_OUT_CLR, c);
			e_out = (d | s) & ~c;
			rd(gpp_pkg::OFF_OUT, e_out);
		end
		// Output enable last; then a change of I/O target must leave the pins alone.
		for (int k = 0; k < 2; k++) begin
			wr(k ? gpp_pkg::OFF_EN1 : gpp_pkg::OFF_OUT_EN_SET, k ? 32'hffffffff : 32'h0000ff00);
			repeat (8) @(negedge clk);
			chk(pad_oe, 32'h0000ff00);
			chk(pad_data & pad_oe, e_out & 32'h0000ff00);
		end
		rd(gpp_pkg::OFF_IN, e_out & 32'h0000ff00);
		wr(gpp_pkg::OFF_OUT_EN_CLR, 32'hffffffff);
		// Each alternate function in turn, entered from the matching I/O mode and left again.
		for (int k = 0; k < 4; k++) begin
			@(posedge clk);
			af[k] <= {32'($random(seed)), 32'hffffffff};
			wr(gpp_pkg::OFF_EN1, {32{k[0]}});
			wr(gpp_pkg::OFF_EN2, {32{k[1]}});
			wr(gpp_pkg::OFF_EN_CLR, 32'hffffffff);
			repeat (8) @(negedge clk);
			chk(grant[k], 32'hffffffff);
			chk(pad_data, af[k].dout);
			chk(pin_val, af[k].dout);
			rd(gpp_pkg::OFF_IN, af[k].dout);
			wr(gpp_pkg::OFF_EN_SET, 32'hffffffff);
			repeat (3) @(negedge clk);
			chk(grant[k], 32'h0);
		end
		// Every event kind on one pin: set, raise, clear and re-arm.
		wr(gpp_pkg::OFF_WAKE_EN, 32'h8);
		foreach (ev[i]) begin
			r = ev[i];
			wr(gpp_pkg::OFF_INT_EN_CLR, 32'hffffffff);
			wr(gpp_pkg::OFF_INT_MOD, {28'h0, r[4], 3'h0});
			wr(gpp_pkg::OFF_INT_POL, {28'h0, r[3], 3'h0});
			wr(gpp_pkg::OFF_DUAL_EDGE, {28'h0, r[2], 3'h0});
			@(posedge clk);
			ext <= {28'h0, r[1], 3'h0};
			repeat (8) @(negedge clk);
			wr(gpp_pkg::OFF_INT_CLR, 32'hffffffff);
			rd(gpp_pkg::OFF_INT_STAT, 32'h0);
			chk({31'h0, irq}, 32'h0);
			wr(gpp_pkg::OFF_INT_EN_SET, 32'h8);
			@(posedge clk);
			ext <= {28'h0, r[0], 3'h0};
			repeat (8) @(negedge clk);
			chk({31'h0, irq}, 32'h1);
			chk({31'h0, wake}, {31'h0, r[4]});
			rd(gpp_pkg::OFF_INT_STAT, 32'h8);
			wr(gpp_pkg::OFF_INT_CLR, 32'h8);
			repeat (3) @(negedge clk);
			rd(gpp_pkg::OFF_INT_STAT, r[4] ? 32'h0 : 32'h8);
		end
		wrap_up();
	end
endmodule
